// file: rtl/mpas_pkg.sv
// Constants, register map and state types of the multiprocessor serial unit.
package mpas_pkg;
	// Register byte offsets.
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_RATE = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_TXHOLD = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_RXHOLD = 8'h14;
	// Mode register fields; the parity fields are stored but have no effect.
	localparam int MODE_SEVEN = 0;
	localparam int MODE_TWOSTOP = 1;
	localparam int MODE_PAR_EN = 2;
	localparam int MODE_PAR_ODD = 3;
	// Control register fields.
	localparam int CTRL_TXEN = 0;
	localparam int CTRL_RXEN = 1;
	localparam int CTRL_TXIE = 2;
	localparam int CTRL_TCIE = 3;
	localparam int CTRL_RXIE = 4;
	localparam int CTRL_MPWAIT = 5;
	// Status register fields.
	localparam int ST_TX_BUFFER_EMPTY_FLAG = 0;
	localparam int ST_RX_FULL_FLAG = 1;
	localparam int ST_OVERRUN_FLAG = 2;
	localparam int ST_FER = 3;
	localparam int ST_TX_COMPLETE_FLAG = 4;
	localparam int ST_MPB = 5;
	localparam int ST_MPB_TRANSMIT_VALUE = 6;
	localparam int ST_RXPIN = 7;
	// Reset values.
	localparam logic [7:0] RATE_RESET = 8'h03;
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	// Sixteen rate ticks make one bit time.
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [2:0] LAST_BIT8 = 3'h7;
	localparam logic [2:0] LAST_BIT7 = 3'h6;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_MPB = 3'b011,
		TX_STOP = 3'b100
	} mpas_tx_state_e;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_MPB = 3'b011,
		RX_STOP = 3'b100
	} mpas_rx_state_e;
endpackage : mpas_pkg

// file: rtl/mpas_rx_if.sv
// Signals between the unit's control logic and its receiver.
interface mpas_rx_if;
	logic tick;
	logic rxd;
	logic enable;
	logic sevenBit;
	logic halted;
	logic done;
	logic stopOk;
	logic mpb;
	logic [7:0] data;
	modport ctrl (output tick, rxd, enable, sevenBit, halted, input done, stopOk, mpb, data);
	modport rcv (input tick, rxd, enable, sevenBit, halted, output done, stopOk, mpb, data);
endinterface : mpas_rx_if

// file: rtl/mpas_rx.sv
// Receiver: start detection, bit-centre sampling and frame delivery.
module mpas_rx
	import mpas_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Link to the control logic.
	mpas_rx_if.rcv link
);
	mpas_rx_state_e state_reg;
	logic [3:0] tickCnt_reg;
	logic [2:0] bitIdx_reg;
	logic [7:0] shift_reg;
	logic prevRxd_reg;
	logic mpb_reg;
	logic stopOk_reg;
	logic done_reg;

	// Named decodes of the sampling points.
	wire startEdge = prevRxd_reg & ~link.rxd;
	wire atMid = link.tick & (tickCnt_reg == TICK_MID);
	wire atLast = link.tick & (tickCnt_reg == TICK_LAST);
	wire [2:0] lastBit = link.sevenBit ? LAST_BIT7 : LAST_BIT8;

	assign link.data = shift_reg;
	assign link.mpb = mpb_reg;
	assign link.stopOk = stopOk_reg;
	assign link.done = done_reg;

	// Edge history; the line idles high so reset assumes mark.
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			prevRxd_reg <= 1'b1;
		else
			prevRxd_reg <= link.rxd;

	// Frame sequencer. A half-bit wait after the edge puts every later sample at a bit centre.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= RX_IDLE;
			tickCnt_reg <= 4'h0;
			bitIdx_reg <= 3'h0;
			shift_reg <= 8'h00;
			mpb_reg <= 1'b0;
			stopOk_reg <= 1'b1;
			done_reg <= 1'b0;
		end
		else
		begin
			done_reg <= 1'b0;
			if (link.tick)
				tickCnt_reg <= tickCnt_reg + 4'h1;
			unique case (state_reg)
				RX_IDLE:
					if (link.enable && !link.halted && startEdge)
					begin
						state_reg <= RX_START;
						tickCnt_reg <= 4'h0;
						bitIdx_reg <= 3'h0;
						shift_reg <= 8'h00;
					end
				RX_START:
					if (atMid)
					begin
						state_reg <= link.rxd ? RX_IDLE : RX_DATA; // Glitches shorter than half a bit are dropped.
						tickCnt_reg <= 4'h0;
					end
				RX_DATA:
					if (atLast)
					begin
						shift_reg[bitIdx_reg] <= link.rxd;
						bitIdx_reg <= bitIdx_reg + 3'h1;
						if (bitIdx_reg == lastBit)
							state_reg <= RX_MPB;
					end
				RX_MPB:
					if (atLast)
					begin
						mpb_reg <= link.rxd;
						state_reg <= RX_STOP;
					end
				RX_STOP:
					if (atLast)
					begin
						stopOk_reg <= link.rxd;
						done_reg <= 1'b1;
						state_reg <= RX_IDLE;
					end
				default:
					state_reg <= RX_IDLE;
			endcase
		end
	end

	// A halted receiver never leaves idle.
	halt_holds_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
		(state_reg == RX_IDLE) && link.halted |=> state_reg == RX_IDLE)
		else $error("Receiver started while halted by an error.");

	// Frame delivery is a single-cycle pulse.
	done_is_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
		done_reg |=> !done_reg)
		else $error("Frame delivery pulse longer than one cycle.");
endmodule : mpas_rx

// file: rtl/mpas_top.sv
// Multiprocessor asynchronous serial unit: APB registers, transmitter and receive control.
// What this block does
// - Every sent frame opens with one low start bit.
// - Seven or eight data bits follow, least significant first.
// - One multiprocessor bit follows, equal to the value latched at load.
// - One or two high stop bits end the frame.
// - The line stays high between frames.
// - Clearing the empty flag makes the unit copy holding into shift register.
// - After the copy the empty flag sets and shifting starts.
// - The empty request rises with the empty flag when enabled.
// - At the stop bit a pending character is loaded and sent without gap.
// - With nothing pending, the complete flag sets and its request rises if enabled.
// - Parity settings are ignored; no parity bit is sent.
// - A waiting receiver drops frames until one carries multiprocessor bit one.
// - Matched stations keep accepting; others drop frames until the next identifier.
// - A DMA write to the holding register clears the empty flag itself.
// - Reception halts until both overrun and framing flags are cleared.
// - The input pin level stays readable for break detection.
// - A low first stop bit is a framing error unless the frame overruns; the second is unchecked.
// - A frame ending while full sets overrun and leaves the holding register.
// - Full and error requests follow their flags when the receive interrupt enable is set.
//
// The APB interface to the registers and the address map were decided locally.
module mpas_top
	import mpas_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// DMA unit writes to the holding register.
	input wire logic dmaTxWrite,
	input wire logic [7:0] dmaTxData,
	// Serial pins and the general-port takeover of the output pin.
	input wire logic rxdIn,
	output logic txdOut,
	input wire logic portDataBit,
	input wire logic pinGeneralOut,
	// Service requests, levels.
	output logic txEmptyRequest,
	output logic txCompleteRequest,
	output logic rxFullRequest,
	output logic rxErrorRequest
);
	logic [3:0] mode_reg;
	logic [7:0] rate_reg;
	logic [5:0] ctrl_reg;
	logic [7:0] txHold_reg;
	logic [7:0] rxHold_reg;
	logic tx_buffer_empty_flag_reg, rx_full_flag_reg, overrun_flag_reg, fer_reg, tx_complete_flag_reg, mpbRx_reg, mpb_transmit_value_reg;
	logic [7:0] divCnt_reg;
	logic [1:0] rxdSync_reg;
	mpas_tx_state_e txState_reg;
	logic [3:0] txTick_reg;
	logic [2:0] txBit_reg;
	logic [7:0] txShift_reg;
	logic txMpb_reg, secondStop_reg, chain_reg, txd_reg;
	mpas_rx_if rxLink ();

	// APB decode; the slave never waits, unmapped addresses answer with an error.
	wire apbAccess = psel & penable;
	wire wrEn = apbAccess & pwrite;
	wire hit = (paddr == ADDR_MODE) | (paddr == ADDR_RATE) | (paddr == ADDR_CTRL) | (paddr == ADDR_TXHOLD)
		| (paddr == ADDR_STATUS) | (paddr == ADDR_RXHOLD);
	wire wrMode = wrEn & (paddr == ADDR_MODE);
	wire wrRate = wrEn & (paddr == ADDR_RATE);
	wire wrCtrl = wrEn & (paddr == ADDR_CTRL);
	wire wrTxHold = wrEn & (paddr == ADDR_TXHOLD);
	wire wrStatus = wrEn & (paddr == ADDR_STATUS);
	assign pready = 1'b1;
	assign pslverr = apbAccess & ~hit;

	// Control fields.
	wire txEn = ctrl_reg[CTRL_TXEN];
	wire sevenBit = mode_reg[MODE_SEVEN];
	wire twoStop = mode_reg[MODE_TWOSTOP]; // Parity fields only read back over APB.
	wire [2:0] txLastBit = sevenBit ? LAST_BIT7 : LAST_BIT8;

	// Rate ticks: sixteen per bit, one every rate_reg+1 clocks.
	wire tick = (divCnt_reg == rate_reg);
	wire txBitEnd = tick & (txTick_reg == TICK_LAST);

	// Transmit events. A write of zero clears a status flag, a one leaves it alone.
	wire swClrTdre = wrStatus & ~pwdata[ST_TX_BUFFER_EMPTY_FLAG] & tx_buffer_empty_flag_reg;
	wire dmaClrTdre = dmaTxWrite & tx_buffer_empty_flag_reg;
	wire idleLoad = (txState_reg == TX_IDLE) & txEn & ~tx_buffer_empty_flag_reg;
	// The last stop bit starts at the end of the multiprocessor bit, or after the first of two stops.
	wire lastStopStart = txBitEnd & ((txState_reg == TX_MPB & ~twoStop)
		| (txState_reg == TX_STOP & twoStop & ~secondStop_reg));
	wire chainLoad = lastStopStart & ~tx_buffer_empty_flag_reg;
	wire txLoad = idleLoad | chainLoad;
	wire tendSet = lastStopStart & tx_buffer_empty_flag_reg;

	// Receive events.
	wire errHalt = overrun_flag_reg | fer_reg;
	wire mpWait = ctrl_reg[CTRL_MPWAIT];
	wire rxDiscard = rxLink.done & mpWait & ~rxLink.mpb;
	wire rxTake = rxLink.done & ~rxDiscard;
	wire rxOverrun = rxTake & rx_full_flag_reg;
	wire rxLoad = rxTake & ~rx_full_flag_reg;
	wire rxFrameErr = rxLoad & ~rxLink.stopOk;

	assign rxLink.tick = tick;
	assign rxLink.rxd = rxdSync_reg[1];
	assign rxLink.enable = ctrl_reg[CTRL_RXEN];
	assign rxLink.sevenBit = sevenBit;
	assign rxLink.halted = errHalt;

	mpas_rx u_rx (
		.clk(clk),
		.arst_n(arst_n),
		.link(rxLink)
	);

	// Service requests follow their flags.
	assign txEmptyRequest = tx_buffer_empty_flag_reg & ctrl_reg[CTRL_TXIE];
	assign txCompleteRequest = tx_complete_flag_reg & ctrl_reg[CTRL_TCIE];
	assign rxFullRequest = rx_full_flag_reg & ctrl_reg[CTRL_RXIE];
	assign rxErrorRequest = errHalt & ctrl_reg[CTRL_RXIE];

	// Read selection; captured in the setup phase so the data comes from a flip-flop.
	wire [7:0] statusView = {rxdSync_reg[1], mpb_transmit_value_reg, mpbRx_reg, tx_complete_flag_reg, fer_reg, overrun_flag_reg, rx_full_flag_reg, tx_buffer_empty_flag_reg};
	wire [7:0] readMux = (paddr == ADDR_MODE) ? {4'h0, mode_reg} :
		(paddr == ADDR_RATE) ? rate_reg :
		(paddr == ADDR_CTRL) ? {2'h0, ctrl_reg} :
		(paddr == ADDR_TXHOLD) ? txHold_reg :
		(paddr == ADDR_STATUS) ? statusView :
		(paddr == ADDR_RXHOLD) ? rxHold_reg : 8'h00;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= {24'h00_0000, readMux};

	// Input pin synchroniser and rate divider.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rxdSync_reg <= 2'b11;
			divCnt_reg <= 8'h00;
		end
		else
		begin
			rxdSync_reg <= {rxdSync_reg[0], rxdIn};
			divCnt_reg <= tick ? 8'h00 : divCnt_reg + 8'h01;
		end
	end

	// Software-written configuration. The wait bit is also cleared by an identifier frame.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode_reg <= MODE_RESET;
			rate_reg <= RATE_RESET;
			ctrl_reg <= CTRL_RESET;
			txHold_reg <= 8'h00;
			mpb_transmit_value_reg <= 1'b0;
		end
		else
		begin
			if (wrMode)
				mode_reg <= pwdata[3:0];
			if (wrRate)
				rate_reg <= pwdata[7:0];
			if (wrCtrl)
				ctrl_reg <= pwdata[5:0];
			else if (rxLink.done && mpWait && rxLink.mpb)
				ctrl_reg[CTRL_MPWAIT] <= 1'b0;
			if (wrTxHold)
				txHold_reg <= pwdata[7:0];
			else if (dmaClrTdre)
				txHold_reg <= dmaTxData;
			if (wrStatus)
				mpb_transmit_value_reg <= pwdata[ST_MPB_TRANSMIT_VALUE];
		end
	end

	// Status flags; a hardware set always wins over a clear in the same cycle.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_buffer_empty_flag_reg <= 1'b1;
			tx_complete_flag_reg <= 1'b1;
			rx_full_flag_reg <= 1'b0;
			overrun_flag_reg <= 1'b0;
			fer_reg <= 1'b0;
			mpbRx_reg <= 1'b0;
			rxHold_reg <= 8'h00;
		end
		else
		begin
			if (!txEn || txLoad)
				tx_buffer_empty_flag_reg <= 1'b1;
			else if (swClrTdre || dmaClrTdre)
				tx_buffer_empty_flag_reg <= 1'b0;
			if (!txEn || tendSet)
				tx_complete_flag_reg <= 1'b1;
			else if (swClrTdre || dmaClrTdre)
				tx_complete_flag_reg <= 1'b0;
			if (rxLoad)
				rx_full_flag_reg <= 1'b1;
			else if (wrStatus && !pwdata[ST_RX_FULL_FLAG])
				rx_full_flag_reg <= 1'b0;
			if (rxOverrun)
				overrun_flag_reg <= 1'b1;
			else if (wrStatus && !pwdata[ST_OVERRUN_FLAG])
				overrun_flag_reg <= 1'b0;
			if (rxFrameErr)
				fer_reg <= 1'b1;
			else if (wrStatus && !pwdata[ST_FER])
				fer_reg <= 1'b0;
			if (rxLoad)
			begin
				rxHold_reg <= rxLink.data;
				mpbRx_reg <= rxLink.mpb;
			end
		end
	end

	// Transmit sequencer; clearing the enable drops the frame and returns to mark.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			txState_reg <= TX_IDLE;
			txTick_reg <= 4'h0;
			txBit_reg <= 3'h0;
			txShift_reg <= 8'h00;
			txMpb_reg <= 1'b0;
			secondStop_reg <= 1'b0;
			chain_reg <= 1'b0;
		end
		else if (!txEn)
			txState_reg <= TX_IDLE;
		else
		begin
			if (tick)
				txTick_reg <= txTick_reg + 4'h1;
			if (txLoad)
			begin
				txShift_reg <= txHold_reg;
				txMpb_reg <= mpb_transmit_value_reg;
			end
			chain_reg <= chainLoad ? 1'b1 : (tendSet ? 1'b0 : chain_reg);
			unique case (txState_reg)
				TX_IDLE:
					if (idleLoad)
					begin
						txState_reg <= TX_START;
						txTick_reg <= 4'h0;
					end
				TX_START:
					if (txBitEnd)
					begin
						txState_reg <= TX_DATA;
						txBit_reg <= 3'h0;
					end
				TX_DATA:
					if (txBitEnd)
					begin
						txBit_reg <= txBit_reg + 3'h1;
						if (txBit_reg == txLastBit)
							txState_reg <= TX_MPB;
					end
				TX_MPB:
					if (txBitEnd)
					begin
						txState_reg <= TX_STOP;
						secondStop_reg <= 1'b0;
					end
				TX_STOP:
					if (txBitEnd)
						if (twoStop && !secondStop_reg)
							secondStop_reg <= 1'b1;
						else
							txState_reg <= chain_reg ? TX_START : TX_IDLE;
				default:
					txState_reg <= TX_IDLE;
			endcase
		end
	end

	// Line level; the general port takes the pin over for a break.
	wire serialBit = (txState_reg == TX_START) ? 1'b0 :
		(txState_reg == TX_DATA) ? txShift_reg[txBit_reg] :
		(txState_reg == TX_MPB) ? txMpb_reg : 1'b1;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			txd_reg <= 1'b1;
		else
			txd_reg <= pinGeneralOut ? portDataBit : serialBit;
	assign txdOut = txd_reg;

	start_bit_low_a: assert property (@(posedge clk) disable iff (!arst_n)
		txState_reg == TX_START && !pinGeneralOut |=> !txdOut)
		else $error("Start bit not low.");
	mark_between_a: assert property (@(posedge clk) disable iff (!arst_n)
		txState_reg == TX_IDLE && !pinGeneralOut |=> txdOut)
		else $error("Line not at mark between frames.");
	mpb_level_a: assert property (@(posedge clk) disable iff (!arst_n)
		txState_reg == TX_MPB && !pinGeneralOut |=> txdOut == $past(txMpb_reg))
		else $error("Multiprocessor bit level wrong.");
	load_sets_empty_a: assert property (@(posedge clk) disable iff (!arst_n)
		txLoad |=> tx_buffer_empty_flag_reg && txShift_reg == $past(txHold_reg) && txState_reg != TX_IDLE)
		else $error("Load did not set the empty flag.");
	empty_request_a: assert property (@(posedge clk) disable iff (!arst_n)
		txLoad && ctrl_reg[CTRL_TXIE] && !wrCtrl |=> txEmptyRequest)
		else $error("Empty request missing after load.");
	complete_set_a: assert property (@(posedge clk) disable iff (!arst_n)
		tendSet && txEn |=> tx_complete_flag_reg && txState_reg == TX_STOP && !chain_reg)
		else $error("Complete flag not set or stop bit cut short.");
	dma_clears_a: assert property (@(posedge clk) disable iff (!arst_n)
		dmaTxWrite && tx_buffer_empty_flag_reg && !wrTxHold && txEn |=> !tx_buffer_empty_flag_reg && txHold_reg == $past(dmaTxData))
		else $error("DMA write did not clear the empty flag.");
	overrun_keeps_a: assert property (@(posedge clk) disable iff (!arst_n)
		rxOverrun |=> overrun_flag_reg && $stable(rxHold_reg))
		else $error("Overrun not flagged or holding register changed.");
	wait_discard_a: assert property (@(posedge clk) disable iff (!arst_n)
		rxDiscard && !rx_full_flag_reg && !wrStatus |=> !rx_full_flag_reg && !$rose(overrun_flag_reg) && !$rose(fer_reg))
		else $error("Discarded frame raised a flag.");
	error_request_a: assert property (@(posedge clk) disable iff (!arst_n)
		(overrun_flag_reg || fer_reg) && ctrl_reg[CTRL_RXIE] |-> rxErrorRequest)
		else $error("Error request missing.");

	frame_sent_c: cover property (@(posedge clk) disable iff (!arst_n) tendSet);
	back_to_back_c: cover property (@(posedge clk) disable iff (!arst_n) chainLoad);
	id_accepted_c: cover property (@(posedge clk) disable iff (!arst_n) rxLoad && mpWait);
	overrun_seen_c: cover property (@(posedge clk) disable iff (!arst_n) rxOverrun);
endmodule : mpas_top

// file: bench/mpas_remote.sv
// Far-side station model: sends frames onto the input line and decodes frames from the output line.
module mpas_remote
(
	// Clock, reset and line.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic txd,
	input wire logic [3:0] nBits,
	output logic rxLine
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BITCLK = 64;
	logic [7:0] gotData [8];
	logic gotMpb [8];
	logic gotStop [8];
	int gotGap [8];
	int frames = 0;
	int idleCnt = 0;

	// The line idles at mark, which stands in for the pull-up of the shared line.
	initial rxLine = 1'b1;

	// One frame: start, eight data bits LSB first, station bit, one stop bit of the given level.
	task automatic sendFrame(input logic [7:0] d, input logic mpb, input logic stopLvl);
		logic [10:0] f;
		begin
			f = {stopLvl, mpb, d, 1'b0};
			for (int i = 0; i < 11; i++)
			begin
				@(posedge clk);
				rxLine <= f[i];
				repeat (BITCLK - 1) @(posedge clk);
			end
			@(posedge clk);
			rxLine <= 1'b1;
			repeat (4) @(posedge clk);
		end
	endtask : sendFrame

	// Holds the line at one level for n clocks, as a break or a return to mark.
	task automatic holdLine(input logic lvl, input int n);
		@(posedge clk);
		rxLine <= lvl;
		repeat (n) @(posedge clk);
	endtask : holdLine

	// Decoder samples at bit centres; the idle count before a start shows whether frames ran gapless.
	initial
	begin
		forever
		begin
			@(posedge clk);
			if (arst_n !== 1'b1 || txd !== 1'b0)
			begin
				idleCnt++;
			end
			else if (frames < 8)
			begin
				gotGap[frames] = idleCnt;
				gotData[frames] = 8'h00;
				repeat (BITCLK / 2) @(posedge clk);
				for (int i = 0; i < nBits; i++)
				begin
					repeat (BITCLK) @(posedge clk);
					gotData[frames][i] = txd;
				end
				repeat (BITCLK) @(posedge clk);
				gotMpb[frames] = txd;
				repeat (BITCLK) @(posedge clk);
				gotStop[frames] = txd;
				idleCnt = 0;
				frames++;
			end
		end
	end
endmodule : mpas_remote

// file: bench/test_multiprocessor_async_serial.sv
// Self-checking testbench of the multiprocessor serial unit.
module test_multiprocessor_async_serial;
	import mpas_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic dmaTxWrite = 1'b0;
	logic [7:0] dmaTxData = 8'h00;
	logic rxdIn;
	logic txdOut;
	logic portDataBit = 1'b1;
	logic pinGeneralOut = 1'b0;
	logic txEmptyRequest;
	logic txCompleteRequest;
	logic rxFullRequest;
	logic rxErrorRequest;
	logic [3:0] rxBits = 4'h8;
	logic [31:0] rd;
	logic err;
	int errors = 0;
	int checks = 0;

	mpas_top DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dmaTxWrite(dmaTxWrite),
		.dmaTxData(dmaTxData), .rxdIn(rxdIn), .txdOut(txdOut), .portDataBit(portDataBit),
		.pinGeneralOut(pinGeneralOut), .txEmptyRequest(txEmptyRequest), .txCompleteRequest(txCompleteRequest),
		.rxFullRequest(rxFullRequest), .rxErrorRequest(rxErrorRequest));
	mpas_remote remote (.clk(clk), .arst_n(arst_n), .txd(txdOut), .nBits(rxBits), .rxLine(rxdIn));

	// A 100 ns clock.
	initial
	begin
		forever #50 clk = ~clk;
	end

	task automatic end_of_test;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp8

	task automatic cmp1(input logic got, input logic exp);
		cmp8({7'h00, got}, {7'h00, exp});
	endtask : cmp1

	// One APB transfer; the request is held until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		begin
			n = 0;
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (pready !== 1'b1 && n < 20);
			if (n >= 20)
			begin
				errors++;
				end_of_test();
			end
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	// Waits, with a bound, until the station model has decoded n frames.
	task automatic waitFrames(input int n);
		int k;
		begin
			k = 0;
			while (remote.frames < n && k < 4000)
			begin
				@(posedge clk);
				k++;
			end
			if (k >= 4000)
			begin
				errors++;
				end_of_test();
			end
			repeat (80) @(posedge clk);
		end
	endtask : waitFrames

	// Cuts a hang short.
	initial
	begin
		repeat (60000) @(posedge clk);
		errors++;
		end_of_test();
	end

	// Main sequence.
	initial
	begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp8(rd[7:0], 8'h91);
		apb(1'b0, 8'h3c, 32'h0);
		cmp1(err, 1'b1);
		apb(1'b1, ADDR_MODE, 32'h0c);
		apb(1'b1, ADDR_CTRL, 32'h0d);
		apb(1'b1, ADDR_TXHOLD, 32'ha5);
		apb(1'b1, ADDR_STATUS, 32'h41);
		apb(1'b1, ADDR_STATUS, 32'h40);
		repeat (4) @(posedge clk);
		cmp1(txEmptyRequest, 1'b1);
		cmp1(txCompleteRequest, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp1(rd[ST_TX_BUFFER_EMPTY_FLAG], 1'b1);
		apb(1'b1, ADDR_TXHOLD, 32'h3c);
		apb(1'b1, ADDR_STATUS, 32'h00);
		waitFrames(2);
		cmp8(remote.gotData[0], 8'ha5);
		cmp1(remote.gotMpb[0], 1'b1);
		cmp1(remote.gotStop[0], 1'b1);
		cmp8(remote.gotData[1], 8'h3c);
		cmp1(remote.gotMpb[1], 1'b0);
		cmp1(remote.gotGap[1] <= 40, 1'b1);
		cmp1(txCompleteRequest, 1'b1);
		cmp1(txdOut, 1'b1);
		@(posedge clk);
		dmaTxWrite <= 1'b1;
		dmaTxData <= 8'h81;
		@(posedge clk);
		dmaTxWrite <= 1'b0;
		waitFrames(3);
		cmp8(remote.gotData[2], 8'h81);
		apb(1'b1, ADDR_MODE, 32'h03);
		rxBits <= 4'h7;
		apb(1'b1, ADDR_TXHOLD, 32'hd5);
		apb(1'b1, ADDR_STATUS, 32'h40);
		waitFrames(4);
		cmp8(remote.gotData[3], 8'h55);
		cmp1(remote.gotMpb[3], 1'b1);
		apb(1'b1, ADDR_MODE, 32'h00);
		apb(1'b1, ADDR_CTRL, 32'h32);
		remote.sendFrame(8'h11, 1'b0, 1'b1);
		cmp1(rxFullRequest, 1'b0);
		remote.sendFrame(8'h42, 1'b1, 1'b1);
		cmp1(rxFullRequest, 1'b1);
		apb(1'b0, ADDR_RXHOLD, 32'h0);
		cmp8(rd[7:0], 8'h42);
		apb(1'b0, ADDR_CTRL, 32'h0);
		cmp8(rd[7:0], 8'h12);
		apb(1'b1, ADDR_STATUS, 32'h01);
		remote.sendFrame(8'h99, 1'b0, 1'b1);
		cmp1(rxFullRequest, 1'b1);
		remote.sendFrame(8'h66, 1'b0, 1'b1);
		cmp1(rxErrorRequest, 1'b1);
		apb(1'b0, ADDR_RXHOLD, 32'h0);
		cmp8(rd[7:0], 8'h99);
		apb(1'b1, ADDR_STATUS, 32'h01);
		remote.sendFrame(8'hc3, 1'b0, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp1(rd[ST_FER], 1'b1);
		cmp1(rd[ST_RXPIN], 1'b1);
		remote.holdLine(1'b0, 8);
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp1(rd[ST_RXPIN], 1'b0);
		remote.holdLine(1'b1, 8);
		apb(1'b1, ADDR_STATUS, 32'h0d);
		remote.sendFrame(8'h24, 1'b0, 1'b1);
		cmp1(rxFullRequest, 1'b0);
		apb(1'b0, ADDR_RXHOLD, 32'h0);
		cmp8(rd[7:0], 8'hc3);
		apb(1'b1, ADDR_STATUS, 32'h01);
		remote.sendFrame(8'h5a, 1'b0, 1'b1);
		apb(1'b0, ADDR_RXHOLD, 32'h0);
		cmp8(rd[7:0], 8'h5a);
		portDataBit <= 1'b0;
		@(posedge clk);
		pinGeneralOut <= 1'b1;
		repeat (3) @(posedge clk);
		cmp1(txdOut, 1'b0);
		end_of_test();
	end
endmodule : test_multiprocessor_async_serial
